// ### logic/mcr_top.sv
`include "mcr_defines.svh"
module mcr_top (
  input  wire  logic                  pclk,
  input  wire  logic                  presetn,
  input  wire  logic                  psel,
  input  wire  logic                  penable,
  input  wire  logic                  pwrite,
  input  wire  logic [7:0]            paddr,
  input  wire  logic [31:0]           pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  output logic                        irq,
  input  wire  logic [1:0]            condition_codes,
  input  wire  logic                  ext_source_option,
  input  wire  logic [`MCR_PA_W-1:0]  port_a_pins,
  input  wire  logic [`MCR_PB_W-1:0]  port_b_pins,
  input  wire  logic [`MCR_PC_W-1:0]  port_c_pins,
  input  wire  mcr_pkg::mcr_port_cfg_s port_a_cfg,
  input  wire  mcr_pkg::mcr_port_cfg_s port_b_cfg,
  input  wire  mcr_pkg::mcr_port_cfg_s port_c_cfg,
  output logic                        external_irq_group_a,
  output logic                        external_irq_group_b,
  output logic                        core_clock_en,
  output logic                        clock_out_pin,
  output logic                        clock_out_oe,
  input  wire  mcr_pkg::mcr_spi_in_s  spi_in,
  input  wire  logic                  spi_select_pin,
  output logic                        spi_master_out_pin,
  output logic                        spi_master_out_oe,
  output logic                        spi_slave_out_pin,
  output logic                        spi_slave_out_oe,
  output logic                        spi_select_level,
  output logic                        spi_select_pin_release
);
  import mcr_pkg::*;

  localparam int GA_W = `MCR_PA_W + `MCR_PC_W;
  localparam int GB_W = `MCR_PB_W + `MCR_PC_W;

  typedef struct packed {
    mcr_sense_s           sense;
    mcr_spi_ovr_s         ovr;
    logic [1:0]           status;
    logic [1:0]           mask;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
    logic                 irq;
    logic [GA_W-1:0]      ga_s1;
    logic [GA_W-1:0]      ga_s2;
    logic [GA_W-1:0]      ga_d;
    logic [GB_W-1:0]      gb_s1;
    logic [GB_W-1:0]      gb_s2;
    logic [GB_W-1:0]      gb_d;
    logic                 sel_s1;
    logic                 sel_s2;
    logic                 req_a;
    logic                 req_b;
    logic [3:0]           div_cnt;
    logic                 tick;
    logic                 clk_out;
    logic                 clk_oe;
    logic                 clk_pin;
    logic                 mosi;
    logic                 mosi_oe;
    logic                 miso;
    logic                 miso_oe;
    logic                 sel_lvl;
    logic                 sel_rel;
  } mcr_state_s;

  mcr_state_s q;
  mcr_state_s next_q;

  // Group synchronisers start at the pulled-up idle level: no false edge or low
  localparam mcr_state_s QRST = '{ga_s1: '1, ga_s2: '1, ga_d: '1,
                                  gb_s1: '1, gb_s2: '1, gb_d: '1,
                                  default: '0};

  logic             setup;
  logic             wr;
  logic             cc_masked;
  logic [1:0]       clr;
  logic [GA_W-1:0]  ga_en;
  logic [GB_W-1:0]  gb_en;
  logic             hit_a;
  logic             hit_b;
  logic [3:0]       div_last;
  mcr_sense_s       wsense;

  // ************************************************************
  // Sensitivity decode, shared by both groups
  // ************************************************************
  function automatic logic group_hit(input logic [1:0]  sens,
                                     input logic [13:0] cur,
                                     input logic [13:0] prev,
                                     input logic [13:0] en);
    logic fall;
    logic rise;
    logic low;
    fall = |(en & prev & ~cur);
    rise = |(en & ~prev & cur);
    low  = |(en & ~cur);
    unique case (sens)
      `MCR_SENS_FALL_LOW: group_hit = fall | low;
      `MCR_SENS_RISE:     group_hit = rise;
      `MCR_SENS_FALL:     group_hit = fall;
      `MCR_SENS_BOTH:     group_hit = fall | rise;
    endcase
  endfunction

  function automatic logic [3:0] div_last_of(input logic [1:0] cp);
    unique case (cp)
      2'b00: div_last_of = `MCR_DIV_LAST_2;
      2'b10: div_last_of = `MCR_DIV_LAST_4;
      2'b01: div_last_of = `MCR_DIV_LAST_8;
      2'b11: div_last_of = `MCR_DIV_LAST_16;
    endcase
  endfunction

  always_comb begin
    next_q    = q;
    setup     = psel & ~penable;
    wr        = psel & penable & q.pready & pwrite;
    cc_masked = (condition_codes == `MCR_CC_MASKED);
    wsense    = mcr_sense_s'(pwdata[7:0]);
    clr       = 2'b00;

    // ************************************************************
    // APB slave: zero wait states, read data prepared in setup
    // ************************************************************
    next_q.pready  = setup;
    next_q.pslverr = 1'b0;
    next_q.prdata  = 32'h0000_0000;
    if (setup) begin
      unique case (paddr)
        `MCR_OFF_SENSE:  next_q.prdata = {24'h00_0000, q.sense};
        `MCR_OFF_SPI:    next_q.prdata = {28'h000_0000, q.ovr[3:0]};
        `MCR_OFF_STATUS: next_q.prdata = {30'h0000_0000, q.status};
        `MCR_OFF_MASK:   next_q.prdata = {30'h0000_0000, q.mask};
        default:         next_q.pslverr = 1'b1;
      endcase
    end
    if (wr) begin
      unique case (paddr)
        `MCR_OFF_SENSE: begin
          next_q.sense.clock_output_enable = wsense.clock_output_enable;
          next_q.sense.core_clock_divider  = wsense.core_clock_divider;
          next_q.sense.slow_select         = wsense.slow_select;
          // Writes outside the masked window would glitch the detectors
          if (cc_masked) begin
            next_q.sense.group_b_sensitivity = wsense.group_b_sensitivity;
            next_q.sense.group_a_sensitivity = wsense.group_a_sensitivity;
          end
        end
        `MCR_OFF_SPI:    next_q.ovr = {4'h0, pwdata[3:0]};
        `MCR_OFF_STATUS: clr = pwdata[1:0];
        `MCR_OFF_MASK:   next_q.mask = pwdata[1:0];
        default: ;
      endcase
    end

    // ************************************************************
    // External interrupt groups
    // ************************************************************
    // Port C joins group A when the option is 0, group B when it is 1
    next_q.ga_s1 = {port_c_pins, port_a_pins};
    next_q.gb_s1 = {port_c_pins, port_b_pins};
    next_q.ga_s2 = q.ga_s1;
    next_q.gb_s2 = q.gb_s1;
    next_q.ga_d  = q.ga_s2;
    next_q.gb_d  = q.gb_s2;
    // Interrupt input means input direction with option bit set
    ga_en = {~port_c_cfg.ddr[`MCR_PC_W-1:0] & port_c_cfg.opt[`MCR_PC_W-1:0]
               & {`MCR_PC_W{~ext_source_option}},
             ~port_a_cfg.ddr & port_a_cfg.opt};
    gb_en = {~port_c_cfg.ddr[`MCR_PC_W-1:0] & port_c_cfg.opt[`MCR_PC_W-1:0]
               & {`MCR_PC_W{ext_source_option}},
             ~port_b_cfg.ddr & port_b_cfg.opt};
    // Low level keeps the request up while a pin is held low
    hit_a = group_hit(q.sense.group_a_sensitivity,
                      q.ga_s2, q.ga_d, ga_en);
    hit_b = group_hit(q.sense.group_b_sensitivity,
                      q.gb_s2, q.gb_d, gb_en);
    next_q.req_a = hit_a & ~cc_masked;
    next_q.req_b = hit_b & ~cc_masked;
    // New event wins over a simultaneous write-one-to-clear
    next_q.status = (q.status & ~clr) | {hit_b, hit_a};
    next_q.irq    = |(next_q.status & next_q.mask);

    // ************************************************************
    // Core clock prescaler and clock-out pin
    // ************************************************************
    div_last = div_last_of(q.sense.core_clock_divider);
    if (!q.sense.slow_select) begin
      next_q.div_cnt = 4'h0;
      next_q.tick    = 1'b1;
    end else if (q.div_cnt >= div_last) begin
      next_q.div_cnt = 4'h0;
      next_q.tick    = 1'b1;
    end else begin
      next_q.div_cnt = q.div_cnt + 4'h1;
      next_q.tick    = 1'b0;
    end
    // Pin can only carry half the tick rate since it comes from a flop
    if (next_q.tick) begin
      next_q.clk_out = ~q.clk_out;
    end
    next_q.clk_oe = q.sense.clock_output_enable;
    next_q.clk_pin = next_q.clk_out & next_q.clk_oe;

    // ************************************************************
    // SPI pin overrides
    // ************************************************************
    next_q.mosi_oe = spi_in.active & spi_in.mosi_oe
                     & ~q.ovr.master_tx_disable;
    next_q.mosi    = spi_in.mosi_out & next_q.mosi_oe;
    next_q.miso_oe = spi_in.miso_oe & ~q.ovr.slave_tx_disable;
    next_q.miso    = spi_in.miso_out & next_q.miso_oe;
    next_q.sel_s1  = spi_select_pin;
    next_q.sel_s2  = q.sel_s1;
    next_q.sel_lvl = q.ovr.select_source_internal ?
                     q.ovr.internal_select_level : q.sel_s2;
    next_q.sel_rel = q.ovr.select_source_internal;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= QRST;
    end else begin
      q <= next_q;
    end
  end

  assign prdata                 = q.prdata;
  assign pready                 = q.pready;
  assign pslverr                = q.pslverr;
  assign irq                    = q.irq;
  assign external_irq_group_a   = q.req_a;
  assign external_irq_group_b   = q.req_b;
  assign core_clock_en          = q.tick;
  assign clock_out_pin          = q.clk_pin;
  assign clock_out_oe           = q.clk_oe;
  assign spi_master_out_pin     = q.mosi;
  assign spi_master_out_oe      = q.mosi_oe;
  assign spi_slave_out_pin      = q.miso;
  assign spi_slave_out_oe       = q.miso_oe;
  assign spi_select_level       = q.sel_lvl;
  assign spi_select_pin_release = q.sel_rel;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_SENS_LOCK: assert property (
    wr && paddr == `MCR_OFF_SENSE && !cc_masked
    |=> $stable({q.sense.group_b_sensitivity, q.sense.group_a_sensitivity}))
    else $error("sensitivity changed while interrupts unmasked");
  AST_SENS_TAKE: assert property (
    wr && paddr == `MCR_OFF_SENSE && cc_masked
    |=> q.sense.group_b_sensitivity == $past(pwdata[7:6]))
    else $error("group b sensitivity write lost");
  AST_RSV_ZERO: assert property (
    pready && psel && paddr == `MCR_OFF_SPI |-> prdata[31:4] == 28'h0)
    else $error("reserved bits read nonzero");
  AST_MOSI_OFF: assert property (
    q.ovr.master_tx_disable |=> !spi_master_out_oe)
    else $error("master output driven while disabled");
  AST_MISO_OFF: assert property (
    q.ovr.slave_tx_disable |=> !spi_slave_out_oe)
    else $error("slave output driven while disabled");
  AST_SEL_SRC: assert property (
    q.ovr.select_source_internal
    |=> spi_select_level == $past(q.ovr.internal_select_level))
    else $error("select level not from internal bit");
  AST_SEL_REL: assert property (
    q.ovr.select_source_internal ##1 q.ovr.select_source_internal
    |-> spi_select_pin_release)
    else $error("select pin not released");
  AST_CLK_OFF: assert property (
    !q.sense.clock_output_enable |=> !clock_out_oe && !clock_out_pin)
    else $error("clock out pin driven while disabled");
  AST_NORMAL: assert property (
    $past(presetn) && !q.sense.slow_select |=> core_clock_en)
    else $error("core clock divided in normal mode");
  AST_DIV2: assert property (
    core_clock_en && q.sense.slow_select
    && q.sense.core_clock_divider == 2'b00 && q.div_cnt == 4'h0
    ##1 $stable(q.sense) |=> core_clock_en)
    else $error("divide by two tick missing");
  AST_REQ_MASK: assert property (
    cc_masked |=> !external_irq_group_a && !external_irq_group_b)
    else $error("request while globally masked");
  AST_LOW_HOLD: assert property (
    q.sense.group_a_sensitivity == `MCR_SENS_FALL_LOW && !cc_masked
    && |(ga_en & ~q.ga_s2) |=> external_irq_group_a)
    else $error("low level request dropped");

  CV_SENS_WR: cover property (wr && paddr == `MCR_OFF_SENSE && cc_masked);
  CV_IRQ_A:   cover property (external_irq_group_a && irq);
  CV_SLOW16:  cover property (core_clock_en && q.sense.slow_select
                              && q.sense.core_clock_divider == 2'b11);
  CV_SEL_INT: cover property (spi_select_pin_release && !spi_select_level);
endmodule

// ### logic/mcr_defines.svh
`ifndef MCR_DEFINES_SVH
`define MCR_DEFINES_SVH

// ************************************************************
// Register map (byte addresses)
// ************************************************************
`define MCR_OFF_SENSE   8'h20
`define MCR_OFF_SPI     8'h40
`define MCR_OFF_STATUS  8'h44
`define MCR_OFF_MASK    8'h48
`define MCR_RESET_BYTE  8'h00

// ************************************************************
// Encodings and counts
// ************************************************************
`define MCR_SENS_FALL_LOW 2'b00
`define MCR_SENS_RISE     2'b01
`define MCR_SENS_FALL     2'b10
`define MCR_SENS_BOTH     2'b11
`define MCR_CC_MASKED     2'b11
`define MCR_DIV_LAST_2    4'h1
`define MCR_DIV_LAST_4    4'h3
`define MCR_DIV_LAST_8    4'h7
`define MCR_DIV_LAST_16   4'hf
`define MCR_PA_W          8
`define MCR_PB_W          8
`define MCR_PC_W          6
`endif

// ### logic/mcr_pkg.sv
`include "mcr_defines.svh"
package mcr_pkg;
  typedef struct packed {
    logic [1:0] group_b_sensitivity;
    logic       clock_output_enable;
    logic [1:0] group_a_sensitivity;
    logic [1:0] core_clock_divider;
    logic       slow_select;
  } mcr_sense_s;

  typedef struct packed {
    logic [3:0] rsv;
    logic       master_tx_disable;
    logic       slave_tx_disable;
    logic       select_source_internal;
    logic       internal_select_level;
  } mcr_spi_ovr_s;

  typedef struct packed {
    logic active;
    logic mosi_out;
    logic mosi_oe;
    logic miso_out;
    logic miso_oe;
  } mcr_spi_in_s;

  typedef struct packed {
    logic [`MCR_PA_W-1:0] ddr;
    logic [`MCR_PA_W-1:0] opt;
  } mcr_port_cfg_s;
endpackage

// ### bench/mcr_pin_model.sv
module mcr_pin_model (
  input  wire logic            pclk,
  input  wire logic            spi_master_out_pin,
  input  wire logic            spi_master_out_oe,
  input  wire logic            spi_slave_out_pin,
  input  wire logic            spi_slave_out_oe,
  output mcr_pkg::mcr_spi_in_s spi_in,
  output logic [7:0]           port_a_pins,
  output logic [7:0]           port_b_pins,
  output logic [5:0]           port_c_pins,
  output logic                 spi_select_pin,
  output logic                 mosi_line,
  output logic                 miso_line
);
  timeunit 1ns;
  timeprecision 100ps;
  import mcr_pkg::*;
  // ****************************************
  // Pins idle high through their pull-ups
  // ****************************************
  initial begin
    spi_in = '0;
    port_a_pins = 8'hff;
    port_b_pins = 8'hff;
    port_c_pins = 6'h3f;
    spi_select_pin = 1'b1;
  end
  // Undriven data lines float to the pull-up, never the stale level
  assign mosi_line = spi_master_out_oe ? spi_master_out_pin : 1'b1;
  assign miso_line = spi_slave_out_oe ? spi_slave_out_pin : 1'b1;
  task automatic set_ab(input logic [7:0] a, input logic [7:0] b);
    @(posedge pclk);
    port_a_pins <= a;
    port_b_pins <= b;
  endtask
  task automatic set_c(input logic [5:0] v);
    @(posedge pclk);
    port_c_pins <= v;
  endtask
  // Overrides come from the legacy register; this task drives the SPI side's active, data and enable inputs
  task automatic set_spi(input mcr_spi_in_s v);
    @(posedge pclk);
    spi_in <= v;
  endtask
  task automatic set_sel(input logic v);
    @(posedge pclk);
    spi_select_pin <= v;
  endtask
endmodule

// ### bench/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import mcr_pkg::*;
  logic          pclk = 1'b0;
  logic          presetn = 1'b0;
  logic          psel = 1'b0;
  logic          penable = 1'b0;
  logic          pwrite = 1'b0;
  logic [7:0]    paddr = 8'h00;
  logic [31:0]   pwdata = 32'h0;
  logic [1:0]    condition_codes = 2'b11;
  logic          ext_source_option = 1'b0;
  mcr_port_cfg_s port_c_cfg = '{ddr: 8'h00, opt: 8'h01};
  mcr_port_cfg_s port_a_cfg = '0;
  mcr_port_cfg_s port_b_cfg = '0;
  logic [31:0]   prdata;
  logic          pready, pslverr, irq, last_err;
  logic          external_irq_group_a, external_irq_group_b;
  logic          core_clock_en, clock_out_pin, clock_out_oe;
  logic          spi_master_out_pin, spi_master_out_oe;
  logic          spi_slave_out_pin, spi_slave_out_oe;
  logic          spi_select_level, spi_select_pin_release;
  logic          spi_select_pin, mosi_line, miso_line;
  logic [7:0]    port_a_pins, port_b_pins;
  logic [5:0]    port_c_pins;
  mcr_spi_in_s   spi_in;
  int            n_errors = 0;
  int            tests_run = 0;
  always #4 pclk = ~pclk;
  mcr_top mcr_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .condition_codes(condition_codes),
    .ext_source_option(ext_source_option), .port_a_pins(port_a_pins),
    .port_b_pins(port_b_pins), .port_c_pins(port_c_pins),
    .port_a_cfg(port_a_cfg), .port_b_cfg(port_b_cfg),
    .port_c_cfg(port_c_cfg),
    .external_irq_group_a(external_irq_group_a),
    .external_irq_group_b(external_irq_group_b),
    .core_clock_en(core_clock_en), .clock_out_pin(clock_out_pin),
    .clock_out_oe(clock_out_oe), .spi_in(spi_in),
    .spi_select_pin(spi_select_pin),
    .spi_master_out_pin(spi_master_out_pin),
    .spi_master_out_oe(spi_master_out_oe),
    .spi_slave_out_pin(spi_slave_out_pin),
    .spi_slave_out_oe(spi_slave_out_oe),
    .spi_select_level(spi_select_level),
    .spi_select_pin_release(spi_select_pin_release));
  mcr_pin_model mcr_pin_model_i (.pclk(pclk),
    .spi_master_out_pin(spi_master_out_pin),
    .spi_master_out_oe(spi_master_out_oe),
    .spi_slave_out_pin(spi_slave_out_pin),
    .spi_slave_out_oe(spi_slave_out_oe), .spi_in(spi_in),
    .port_a_pins(port_a_pins), .port_b_pins(port_b_pins),
    .port_c_pins(port_c_pins), .spi_select_pin(spi_select_pin),
    .mosi_line(mosi_line), .miso_line(miso_line));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", s, e, g);
    end
  endtask
  // Holds the request until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      n_errors++;
      print_verdict();
    end
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask
  task automatic count_req(input int g, output int n);
    n = 0;
    repeat (12) begin
      @(negedge pclk);
      n += ((g ? external_irq_group_b : external_irq_group_a) === 1'b1);
    end
    @(posedge pclk);
  endtask
  function automatic logic [31:0] spi_pins();
    return {26'h0, spi_master_out_oe, spi_slave_out_oe, mosi_line,
            miso_line, spi_select_level, spi_select_pin_release};
  endfunction
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs();
    logic [31:0] q;
    apb(1'b0, 8'h20, 32'h0, q);
    chk("sense reset", 32'h0, q);
    apb(1'b0, 8'h40, 32'h0, q);
    chk("override reset", 32'h0, q);
    apb(1'b0, 8'h10, 32'h0, q);
    chk("unmapped err", 32'h1, {31'h0, last_err});
    condition_codes <= 2'b00;
    wr(8'h20, 32'hff);
    apb(1'b0, 8'h20, 32'h0, q);
    chk("sense locked", 32'h27, q);
    condition_codes <= 2'b11;
    wr(8'h20, 32'hff);
    apb(1'b0, 8'h20, 32'h0, q);
    chk("sense open", 32'hff, q);
    $display("test regs done");
  endtask
  task automatic t_clk();
    logic [1:0] cp [5] = '{2'b00, 2'b10, 2'b01, 2'b11, 2'b00};
    int dv [5] = '{2, 4, 8, 16, 1};
    int ticks, tog;
    logic prev;
    for (int i = 0; i < 5; i++) begin
      wr(8'h20, {26'h0, 3'b100, cp[i], i < 4});
      repeat (20) @(negedge pclk);
      ticks = 0;
      tog = 0;
      prev = clock_out_pin;
      repeat (32) begin
        @(negedge pclk);
        ticks += (core_clock_en === 1'b1);
        tog += (clock_out_pin !== prev);
        prev = clock_out_pin;
      end
      chk("core ticks", 32 / dv[i], ticks);
      chk("clock out toggles", 32 / dv[i], tog);
      chk("clock out oe", 32'h1, {31'h0, clock_out_oe});
    end
    wr(8'h20, 32'h0);
    repeat (3) @(negedge pclk);
    chk("clock out off", 32'h0, {30'h0, clock_out_oe, clock_out_pin});
    @(posedge pclk);
    $display("test clock done");
  endtask
  task automatic t_spi();
    logic [31:0] q;
    mcr_pin_model_i.set_spi(5'b10101);
    wr(8'h40, 32'hff);
    apb(1'b0, 8'h40, 32'h0, q);
    chk("override read", 32'h0f, q);
    repeat (4) @(negedge pclk);
    chk("spi off", 32'h0f, spi_pins());
    @(posedge pclk);
    mcr_pin_model_i.set_sel(1'b0);
    wr(8'h40, 32'h00);
    repeat (5) @(negedge pclk);
    chk("spi on", 32'h30, spi_pins());
    @(posedge pclk);
    mcr_pin_model_i.set_spi(5'b00101);
    repeat (3) @(negedge pclk);
    chk("spi inactive", 32'h18, spi_pins());
    @(posedge pclk);
    $display("test serial done");
  endtask
  task automatic t_irq();
    int fe [4] = '{1, 0, 1, 1};
    int re [4] = '{1, 1, 0, 1};
    int cf, cr;
    logic [31:0] q;
    for (int g = 0; g < 2; g++) begin
      for (int c = 0; c < 4; c++) begin
        condition_codes <= 2'b11;
        ext_source_option <= g[0];
        wr(8'h20, g ? {24'h0, c[1:0], 6'h0} : {27'h0, c[1:0], 3'h0});
        condition_codes <= 2'b00;
        mcr_pin_model_i.set_c(6'h3e);
        count_req(g, cf);
        mcr_pin_model_i.set_c(6'h3f);
        count_req(g, cr);
        chk("fall req", fe[c], c ? cf : (cf > 6));
        chk("rise req", re[c], c ? cr : (cr < 4));
      end
    end
    apb(1'b0, 8'h44, 32'h0, q);
    chk("status", 32'h3, q);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(8'h48, 32'h1);
    repeat (2) @(negedge pclk);
    chk("irq on", 32'h1, {31'h0, irq});
    wr(8'h44, 32'h1);
    apb(1'b0, 8'h44, 32'h0, q);
    chk("status clear", 32'h2, q);
    repeat (2) @(negedge pclk);
    chk("irq off", 32'h0, {31'h0, irq});
    condition_codes <= 2'b11;
    ext_source_option <= 1'b0;
    wr(8'h20, 32'h10);
    mcr_pin_model_i.set_c(6'h3e);
    count_req(0, cf);
    chk("cc blocks req", 32'h0, cf);
    mcr_pin_model_i.set_c(6'h3f);
    count_req(0, cr);
    condition_codes <= 2'b00;
    port_c_cfg <= '{ddr: 8'h01, opt: 8'h01};
    mcr_pin_model_i.set_c(6'h3e);
    count_req(0, cf);
    chk("output pin req", 32'h0, cf);
    $display("test interrupt done");
  endtask
  task automatic t_ports();
    int cf;
    condition_codes <= 2'b11;
    port_a_cfg <= '{ddr: 8'h00, opt: 8'h80};
    port_b_cfg <= '{ddr: 8'h00, opt: 8'h01};
    wr(8'h20, 32'h50);
    condition_codes <= 2'b00;
    mcr_pin_model_i.set_ab(8'h7f, 8'hff);
    count_req(0, cf);
    chk("port a fall", 32'h1, cf);
    mcr_pin_model_i.set_ab(8'hff, 8'hfe);
    count_req(1, cf);
    chk("port b fall", 32'h0, cf);
    mcr_pin_model_i.set_ab(8'hff, 8'hff);
    count_req(1, cf);
    chk("port b rise", 32'h1, cf);
    $display("test ports done");
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_clk();
    t_spi();
    t_irq();
    t_ports();
    print_verdict();
  end
endmodule
